// ===== ees_top.sv
`timescale 1ns/10ps
module ees_top import ees_pkg::*; #(
    parameter int unsigned P_PROG_CYCLES = PROG_CYCLES
) (
    input  wire logic        i_mclk,
    input  wire logic        i_srst,
    input  wire logic        i_sck,
    input  wire logic        i_cs_n,
    input  wire logic        i_si,
    input  wire logic        i_hold_n,
    input  wire logic        i_wp_n,
    output logic             o_so,
    output logic             o_so_oe,
    output logic [15:0]      o_rd_addr,
    input  wire logic [7:0]  i_rd_data,
    output logic             o_prog_start,
    output logic [15:0]      o_prog_addr,
    output logic             o_prog_id_page,
    output logic             o_prog_status,
    output logic [7:0]       o_prog_bytes,
    output logic [7:0]       o_status,
    output logic             o_busy,
    output logic             o_standby
);

    // ----------------------------------------
    // link side state (serial clock domain)
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]  sreg;
        logic [2:0]  bcnt;
        logic [7:0]  nbyte;
        logic [7:0]  op;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [15:0] rptr;
        logic        drv;
    } ees_link_t;

    // falling edge output stage
    typedef struct packed {
        logic       so;
        logic [7:0] obyte;
        logic       drv;
    } ees_fall_t;

    // ----------------------------------------
    // core state (system clock domain)
    // ----------------------------------------
    typedef struct packed {
        logic        cs_d;
        logic        armed;
        logic        seen;
        logic        busy_at;
        logic        write_latch_bit;
        logic        pin_en;
        logic        id_sel;
        logic        id_lock;
        logic [1:0]  guard;
        logic        id_pend;
        logic        start;
        logic [15:0] paddr;
        logic        pid;
        logic        psr;
        logic [7:0]  pcnt;
        logic        standby;
    } ees_core_t;

    ees_link_t lk;
    ees_link_t next_lk;
    ees_fall_t fl;
    ees_fall_t next_fl;
    ees_core_t cr;
    ees_core_t next_cr;

    logic       fresh;
    logic [7:0] lk_byte;
    logic [2:0] c_bcnt;
    logic [7:0] c_nbyte;
    logic [7:0] c_op;
    logic [7:0] stat_l;
    logic [7:0] out_src;
    logic [2:0] pin_s;
    logic       cs_s;
    logic       wp_s;
    logic       fresh_s;
    logic       cs_fall;
    logic       cs_rise;
    logic       hw_lock;
    logic       arr_ok;
    logic       busy;
    logic       prog_done;
    logic [7:0] status;

    // ----------------------------------------
    // frame start marker
    // ----------------------------------------

    // set while deselected, cleared by the first clock of a frame;
    // the frame record survives deselect until this edge
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            fresh <= 1'b1;
        end else if (i_hold_n) begin
            fresh <= 1'b0;
        end
    end

    // status image carried into the serial clock domain
    ees_sync #(
        .W (8)
    ) u_stat_sync (
        .i_clk (i_sck),
        .i_d   (status),
        .o_q   (stat_l)
    );

    // ----------------------------------------
    // input shifter and instruction decode
    // ----------------------------------------

    always_comb begin
        next_lk = lk;
        lk_byte = {lk.sreg[6:0], i_si};
        c_bcnt  = fresh ? 3'h0 : lk.bcnt;
        c_nbyte = fresh ? 8'h00 : lk.nbyte;
        c_op    = (c_nbyte == BY_OPCODE) ? lk_byte : lk.op;
        if (fresh) begin
            next_lk.drv = 1'b0;
        end
        if (i_hold_n) begin
            next_lk.sreg  = lk_byte;
            next_lk.bcnt  = c_bcnt + 3'h1;
            next_lk.nbyte = c_nbyte;
            if (c_bcnt == 3'h7) begin
                if (c_nbyte != NB_MAX) begin
                    next_lk.nbyte = c_nbyte + 8'h01;
                end
                case (c_nbyte)
                    BY_OPCODE: begin
                        next_lk.op = lk_byte;
                    end
                    BY_ADDR_HI: begin
                        next_lk.addr[15:8] = lk_byte;
                        next_lk.wdata      = lk_byte;
                    end
                    BY_ADDR_LO: begin
                        next_lk.addr[7:0] = lk_byte;
                    end
                    BY_DATA0: begin
                        next_lk.wdata = lk_byte;
                    end
                    default: ;
                endcase
                if (c_op == OP_STAT_RD) begin
                    next_lk.drv = 1'b1;
                end
                if (c_op == OP_ARR_RD && c_nbyte >= BY_ADDR_LO && !stat_l[SB_BUSY_BIT]) begin
                    next_lk.drv  = 1'b1;
                    next_lk.rptr = (c_nbyte == BY_ADDR_LO) ? {lk.addr[15:8], lk_byte} : lk.rptr + 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge i_sck) begin
        lk <= next_lk;
    end

    // ----------------------------------------
    // output shifter
    // ----------------------------------------

    // status read returns the full register, array read the addressed byte
    assign out_src = (lk.op == OP_STAT_RD) ? stat_l : i_rd_data;

    always_comb begin
        next_fl = fl;
        if (i_hold_n) begin
            if (lk.bcnt == 3'h0) begin
                next_fl.so    = out_src[7];
                next_fl.obyte = out_src;
            end else begin
                next_fl.so = fl.obyte[3'h7 - lk.bcnt];
            end
            next_fl.drv = lk.drv & ~fresh;
        end
    end

    // deselect clears the drive at once
    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            fl <= '0;
        end else begin
            fl <= next_fl;
        end
    end

    // float outside read phases and during pause
    assign o_so      = fl.so;
    assign o_so_oe   = fl.drv & ~i_cs_n & i_hold_n;
    assign o_rd_addr = lk.rptr;

    // ----------------------------------------
    // pin synchronisers and programming timer
    // ----------------------------------------

    ees_sync #(
        .W (3)
    ) u_pin_sync (
        .i_clk (i_mclk),
        .i_d   ({i_cs_n, i_wp_n, fresh}),
        .o_q   (pin_s)
    );

    assign cs_s    = pin_s[2];
    assign wp_s    = pin_s[1];
    assign fresh_s = pin_s[0];

    // runs from the closing select edge
    ees_timer #(
        .CYCLES (P_PROG_CYCLES)
    ) u_timer (
        .i_mclk  (i_mclk),
        .i_srst  (i_srst),
        .i_start (cr.start),
        .o_busy  (busy),
        .o_done  (prog_done)
    );

    // ----------------------------------------
    // status register image
    // ----------------------------------------

    // bit layout, bit 5 constant zero
    // busy comes only from the timer
    always_comb begin
        status                = 8'h00;
        status[SB_PIN_EN]     = cr.pin_en;
        status[SB_ID_SEL]     = cr.id_sel;
        status[SB_ID_LOCK]    = cr.id_lock;
        status[SB_GUARD_HI]   = cr.guard[1];
        status[SB_GUARD_LO]   = cr.guard[0];
        status[SB_LATCH_BIT]  = cr.write_latch_bit & ~prog_done; // latch reads clear as busy drops
        status[SB_BUSY_BIT]   = busy;
    end

    // ----------------------------------------
    // command execution at frame end
    // ----------------------------------------
    assign cs_fall = cr.cs_d & ~cs_s;
    assign cs_rise = ~cr.cs_d & cs_s;

    assign hw_lock = cr.pin_en & ~wp_s;

    assign arr_ok = cr.id_sel ?
                    (!cr.id_lock && cr.guard != GUARD_FULL && !ees_guarded(cr.guard, lk.addr[14:0])) :
                    !ees_guarded(cr.guard, lk.addr[14:0]);

    always_comb begin
        next_cr       = cr;
        next_cr.start = 1'b0;
        next_cr.cs_d  = cs_s;
        if (cs_fall) begin
            next_cr.armed   = 1'b1;
            next_cr.seen    = 1'b0;
            next_cr.busy_at = busy;
        end
        if (!cs_s && !fresh_s) begin
            next_cr.seen = 1'b1;
        end
        if (cs_rise) begin
            next_cr.armed = 1'b0;
            if (cr.armed && cr.seen && !cr.busy_at && !busy && lk.bcnt == 3'h0) begin
                case (lk.op)
                    OP_SET_LATCH: begin
                        if (lk.nbyte == NB_CMD) begin
                            next_cr.write_latch_bit = 1'b1;
                        end
                    end
                    OP_CLR_LATCH: begin
                        if (lk.nbyte == NB_CMD) begin
                            next_cr.write_latch_bit = 1'b0;
                        end
                    end
                    // latch and pin gate status write
                    OP_STAT_WR: begin
                        if (lk.nbyte >= NB_STAT_WR && cr.write_latch_bit && !hw_lock) begin
                            // only bits 7, 6, 4, 3, 2
                            next_cr.pin_en = lk.wdata[SB_PIN_EN];
                            next_cr.guard  = lk.wdata[SB_GUARD_HI:SB_GUARD_LO];
                            if (!(lk.wdata[SB_ID_SEL] && lk.wdata[SB_ID_LOCK])) begin
                                next_cr.id_sel  = lk.wdata[SB_ID_SEL];
                                next_cr.id_lock = cr.id_lock | lk.wdata[SB_ID_LOCK];
                            end
                            next_cr.start = 1'b1;
                            next_cr.psr   = 1'b1;
                        end
                    end
                    OP_ARR_WR: begin
                        if (lk.nbyte >= NB_WR_MIN && cr.write_latch_bit && arr_ok) begin
                            next_cr.start   = 1'b1;
                            next_cr.psr     = 1'b0;
                            next_cr.paddr   = lk.addr;
                            next_cr.pid     = cr.id_sel;
                            next_cr.id_pend = cr.id_sel;
                            next_cr.pcnt    = lk.nbyte - NB_RD_HDR;
                        end
                    end
                    OP_ARR_RD: begin
                        if (lk.nbyte >= NB_RD_HDR) begin
                            next_cr.id_sel = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (prog_done) begin
            next_cr.write_latch_bit     = 1'b0;
            next_cr.id_pend = 1'b0;
            if (cr.id_pend) begin
                next_cr.id_sel = 1'b0;
            end
        end
        next_cr.standby = cs_s & ~busy;
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            cr <= '0;
        end else begin
            cr <= next_cr;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------

    assign o_prog_start   = cr.start;
    assign o_prog_addr    = cr.paddr;
    assign o_prog_id_page = cr.pid;
    assign o_prog_status  = cr.psr;
    assign o_prog_bytes   = cr.pcnt;
    assign o_status       = status;
    assign o_busy         = busy;
    assign o_standby      = cr.standby;

endmodule : ees_top

// ===== ees_pkg.sv
package ees_pkg;


// ----------------------------------------
// instruction opcodes
// ----------------------------------------
localparam logic [7:0] OP_SET_LATCH = 8'h06;
localparam logic [7:0] OP_CLR_LATCH = 8'h04;
localparam logic [7:0] OP_STAT_RD   = 8'h05;
localparam logic [7:0] OP_STAT_WR   = 8'h01;
localparam logic [7:0] OP_ARR_RD    = 8'h03;
localparam logic [7:0] OP_ARR_WR    = 8'h02;

// ----------------------------------------
// status register layout
// ----------------------------------------
localparam int unsigned SB_PIN_EN   = 7;
localparam int unsigned SB_ID_SEL   = 6;
localparam int unsigned SB_ID_LOCK  = 4;
localparam int unsigned SB_GUARD_HI = 3;
localparam int unsigned SB_GUARD_LO = 2;
localparam int unsigned SB_LATCH_BIT = 1;
localparam int unsigned SB_BUSY_BIT  = 0;
localparam logic [1:0]  GUARD_NONE  = 2'h0;
localparam logic [1:0]  GUARD_QTR   = 2'h1;
localparam logic [1:0]  GUARD_HALF  = 2'h2;
localparam logic [1:0]  GUARD_FULL  = 2'h3;
localparam logic [14:0] QTR_BASE    = 15'h6000;
localparam logic [14:0] HALF_BASE   = 15'h4000;

// ----------------------------------------
// frame byte positions and counts
// ----------------------------------------
localparam logic [7:0] BY_OPCODE  = 8'h00;
localparam logic [7:0] BY_ADDR_HI = 8'h01;
localparam logic [7:0] BY_ADDR_LO = 8'h02;
localparam logic [7:0] BY_DATA0   = 8'h03;
localparam logic [7:0] NB_CMD     = 8'h01;
localparam logic [7:0] NB_STAT_WR = 8'h02;
localparam logic [7:0] NB_RD_HDR  = 8'h03;
localparam logic [7:0] NB_WR_MIN  = 8'h04;
localparam logic [7:0] NB_MAX     = 8'hff;

// ----------------------------------------
// timing
// ----------------------------------------
localparam int unsigned MCLK_PERIOD_NS = 10;
localparam int unsigned PROG_TIME_MS   = 5;
localparam int unsigned PROG_CYCLES    = PROG_TIME_MS * 1000000 / MCLK_PERIOD_NS;

typedef enum logic [0:0] {
    TM_IDLE = 1'b0,
    TM_RUN  = 1'b1
} ees_tm_state_t;

// address inside the range chosen by the guard field
function automatic logic ees_guarded(input logic [1:0] guard, input logic [14:0] addr);
    case (guard)
        GUARD_NONE: ees_guarded = 1'b0;
        GUARD_QTR:  ees_guarded = (addr >= QTR_BASE);
        GUARD_HALF: ees_guarded = (addr >= HALF_BASE);
        default:    ees_guarded = 1'b1;
    endcase
endfunction : ees_guarded

endpackage : ees_pkg

// ===== ees_sync.sv
`timescale 1ns/10ps
module ees_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         i_clk,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } ees_sync_t;

    ees_sync_t r;
    ees_sync_t next_r;

    if (W < 1) begin : g_bad_w
        $error("ees_sync: width must be at least one");
    end

    // two-stage chain, first stage feeds only the second
    always_comb begin
        next_r.meta = i_d;
        next_r.q    = r.meta;
    end

    always_ff @(posedge i_clk) begin
        r <= next_r;
    end

    assign o_q = r.q;
endmodule : ees_sync

// ===== ees_timer.sv
`timescale 1ns/10ps
module ees_timer import ees_pkg::*; #(
    parameter int unsigned CYCLES = PROG_CYCLES
) (
    input  wire logic i_mclk,
    input  wire logic i_srst,
    input  wire logic i_start,
    output logic      o_busy,
    output logic      o_done
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    typedef struct packed {
        ees_tm_state_t st;
        logic [CW-1:0] cnt;
        logic          done;
    } ees_tm_t;

    ees_tm_t r;
    ees_tm_t next_r;

    if (CYCLES < 1) begin : g_bad_cycles
        $error("ees_timer: programming time must be at least one cycle");
    end

    // busy for exactly CYCLES clocks, then one done pulse
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        case (r.st)
            TM_IDLE: begin
                if (i_start) begin
                    next_r.st  = TM_RUN;
                    next_r.cnt = CW'(CYCLES - 1);
                end
            end
            TM_RUN: begin
                if (r.cnt == '0) begin
                    next_r.st   = TM_IDLE;
                    next_r.done = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - CW'(1);
                end
            end
            default: next_r.st = TM_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_busy = (r.st == TM_RUN);
    assign o_done = r.done;
endmodule : ees_timer

// ===== ees_top_assertions.sv
`timescale 1ns/10ps
module ees_chk #(
    parameter int unsigned P_PROG_CYCLES = 20
) (
    input  wire logic       i_mclk,
    input  wire logic       i_srst,
    input  wire logic       i_sck,
    input  wire logic       i_cs_n,
    input  wire logic       i_hold_n,
    input  wire logic       o_so,
    input  wire logic       o_so_oe,
    input  wire logic       o_prog_start,
    input  wire logic       o_prog_status,
    input  wire logic [7:0] o_status,
    input  wire logic       o_busy,
    input  wire logic       o_standby
);
    int unsigned busy_len;

    // length of the current programming run
    always_ff @(posedge i_mclk) begin
        if (i_srst || !o_busy) begin
            busy_len <= 0;
        end else begin
            busy_len <= busy_len + 1;
        end
    end

    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    chk_oe_cs_off: assert property (i_cs_n |-> !o_so_oe)
        else $error("output driven while deselected");
    chk_oe_pause_off: assert property (!i_hold_n |-> !o_so_oe)
        else $error("output driven during pause");
    chk_so_fall_only: assert property (i_sck && $past(i_sck) && o_so_oe && $past(o_so_oe) |-> $stable(o_so))
        else $error("output moved while clock high");
    chk_oe_rise_low: assert property ($rose(o_so_oe) |-> !i_sck && !i_cs_n)
        else $error("output enabled off a falling edge");
    chk_busy_mirror: assert property (o_status[0] == o_busy)
        else $error("busy bit differs from busy");
    chk_zero_bit: assert property (o_status[5] == 1'b0)
        else $error("status bit 5 not zero");
    chk_start_busy: assert property (o_prog_start |-> ##[0:2] o_busy)
        else $error("programming did not start");
    chk_busy_len: assert property ($fell(o_busy) |-> busy_len + 1 >= P_PROG_CYCLES && busy_len <= P_PROG_CYCLES + 1)
        else $error("programming run length wrong");
    chk_latch_drop: assert property ($fell(o_busy) |-> !o_status[1])
        else $error("write latch kept after programming");
    chk_busy_quiet: assert property (o_busy && $past(o_busy) |-> !o_prog_start)
        else $error("programming accepted while busy");
    chk_standby_idle: assert property ($past(o_busy) |-> !o_standby)
        else $error("standby while programming");

    cover property (o_prog_start && o_prog_status);
    cover property (o_prog_start && !o_prog_status);
    cover property ($rose(o_so_oe));
endmodule : ees_chk

bind ees_top ees_chk #(.P_PROG_CYCLES(P_PROG_CYCLES)) u_chk (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_hold_n(i_hold_n),
    .o_so(o_so), .o_so_oe(o_so_oe), .o_prog_start(o_prog_start), .o_prog_status(o_prog_status),
    .o_status(o_status), .o_busy(o_busy), .o_standby(o_standby));

// ===== ees_host.sv
`timescale 1ns/10ps
module ees_host (
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_si,
    output logic      o_hold_n,
    input  wire logic i_so
);
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    logic [7:0] sh;

    // idle pins
    initial begin
        o_sck = 1'b0;
        o_si = 1'b0;
        o_hold_n = 1'b1;
        // deselect just after time zero so the frame logic sees a clean edge
        #1 o_cs_n = 1'b1;
    end

    // one frame, bits msb first; clock stands still outside it
    // framed by chip select
    task automatic run(input int pz, input logic cpol);
        o_sck = cpol;
        #30 o_cs_n = 1'b0;
        #24;
        for (int i = 0; i < 8 * txq.size(); i++) begin
            o_sck = 1'b0;
            if (i == pz) begin
                #6 o_hold_n = 1'b0; // clear of the falling edge
                o_si = ~o_si;
                #96 o_hold_n = 1'b1;
            end
            o_si = txq[i / 8][7 - i % 8];
            #24 o_sck = 1'b1;
            sh = {sh[6:0], i_so};
            if (i % 8 == 7) rxq.push_back(sh);
            #24;
        end
        if (!cpol) o_sck = 1'b0;
        #24 o_cs_n = 1'b1;
        o_si = ~o_si;
        #48;
    endtask : run
endmodule : ees_host

// ===== spi_eeprom_command_protect_test.sv
`timescale 1ns/10ps
module spi_eeprom_command_protect_test import ees_pkg::*;;
    localparam int unsigned PC = 400;
    logic        mclk, srst, sck, cs_n, si, hold_n, wp_n, so, so_oe, so_w;
    logic        prog_start, prog_id, prog_st, busy, standby;
    logic [15:0] rd_addr, prog_addr;
    logic [7:0]  rd_data, prog_bytes, status;
    logic [7:0]  bad[3] = '{8'h00, 8'h07, 8'hff};
    logic [15:0] lo[4] = '{16'h0000, 16'h5fff, 16'h3fff, 16'h0000};
    logic [15:0] hi[4] = '{16'h7fff, 16'h6000, 16'h4000, 16'h7fff};
    int          okn[4] = '{2, 1, 1, 0};
    int          error_cnt = 0;
    int          n_compared = 0;
    int          starts = 0;
    int          n;

    // array data seen by the reader; released output reads inverted
    assign rd_data = rd_addr[7:0] ^ 8'h5a;
    assign so_w = so_oe ? so : ~so;

    ees_top #(.P_PROG_CYCLES(PC)) u_dut (
        .i_mclk(mclk), .i_srst(srst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n),
        .i_wp_n(wp_n), .o_so(so), .o_so_oe(so_oe), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
        .o_prog_start(prog_start), .o_prog_addr(prog_addr), .o_prog_id_page(prog_id),
        .o_prog_status(prog_st), .o_prog_bytes(prog_bytes), .o_status(status), .o_busy(busy),
        .o_standby(standby));
    ees_host u_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n), .i_so(so_w));

    // system clock and accepted-programming counter
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) if (prog_start === 1'b1) starts <= starts + 1;

    task automatic end_of_test;
        if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wait_ready;
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge mclk);
        chk("ready", 16'h0000, {15'h0000, busy});
        if (busy !== 1'b0) end_of_test();
    endtask : wait_ready

    task automatic send(input logic [7:0] q[$], input int pz = -1, input logic cpol = 0, input bit wt = 1);
        @(posedge mclk) #1;
        u_host.txq = q;
        u_host.rxq.delete();
        u_host.run(pz, cpol);
        repeat (8) @(posedge mclk);
        if (wt) wait_ready();
    endtask : send

    // status read of three bytes with a pause inside
    task automatic st(input logic [7:0] e, input logic cpol = 0);
        send('{OP_STAT_RD, 8'h00, 8'h00}, 11, cpol, 0);
        chk("status pin", e, u_host.rxq[1]);
        chk("status again", e, u_host.rxq[2]);
        chk("status port", e, status);
    endtask : st

    // latch set in its own frame
    task automatic wr(input logic [7:0] v);
        send('{OP_SET_LATCH});
        send('{OP_STAT_WR, v});
    endtask : wr

    task automatic aw(input logic [15:0] a, input bit wt = 1);
        send('{OP_SET_LATCH});
        send('{OP_ARR_WR, a[15:8], a[7:0], 8'hc3, 8'h3c}, -1, 0, wt);
    endtask : aw

    initial begin
        srst = 1'b1;
        wp_n = 1'b1;
        repeat (8) @(posedge mclk);
        #1 srst = 1'b0;
        repeat (10) @(posedge mclk);
        chk("standby", 16'h0001, standby);
        chk("oe idle", 16'h0000, so_oe);
        st(8'h00, 0);
        st(8'h00, 1);
        send('{OP_SET_LATCH});
        st(8'h02);
        for (int i = 0; i < 3; i++) send('{bad[i], 8'h8c});
        st(8'h02);
        send('{OP_CLR_LATCH});
        st(8'h00);
        send('{OP_ARR_WR, 8'h01, 8'h00, 8'h11});
        chk("no latch", 0, starts);
        aw(16'h1234, 0);
        chk("starts", 1, starts);
        chk("addr", 16'h1234, prog_addr);
        chk("bytes", 16'h0002, prog_bytes);
        chk("kind", 16'h0000, {prog_st, prog_id});
        st(8'h03);
        send('{OP_ARR_WR, 8'h00, 8'h20, 8'h11}, -1, 0, 0);
        chk("busy ignore", 1, starts);
        wait_ready();
        st(8'h00);
        for (int g = 0; g < 4; g++) begin
            wr({4'h0, 2'(g), 2'b11});
            st({4'h0, 2'(g), 2'b00});
            n = starts;
            aw(lo[g]);
            aw(hi[g]);
            chk("guard", 16'(n + okn[g]), 16'(starts));
        end
        wr(8'h80);
        st(8'h80);
        #1 wp_n = 1'b0;
        n = starts;
        wr(8'h8c);
        st(8'h82);
        aw(16'h0100);
        chk("pin guard", 16'(n + 1), 16'(starts));
        #1 wp_n = 1'b1;
        wr(8'h00);
        st(8'h00);
        wr(8'h50);
        st(8'h00);
        wr(8'h40);
        st(8'h40);
        aw(16'h0005, 0);
        chk("id page", 16'h0001, prog_id);
        wait_ready();
        st(8'h00);
        send('{OP_ARR_RD, 8'h12, 8'h34, 8'h00, 8'h00});
        chk("read 0", 16'h006e, u_host.rxq[3]);
        chk("read 1", 16'h006f, u_host.rxq[4]);
        wr(8'h40);
        send('{OP_ARR_RD, 8'h00, 8'h01, 8'h00});
        st(8'h00);
        wr(8'h10);
        st(8'h10);
        wr(8'h40);
        st(8'h50);
        n = starts;
        aw(16'h0005);
        chk("locked", 16'(n), 16'(starts));
        end_of_test();
    end
endmodule : spi_eeprom_command_protect_test
